/* File: design/wdf_pkg.sv */
/*
 Constants for the waveform dead-time and fault control block.
 Assumes a single peripheral clock and an 8-bit register port.
*/
// Notes on behaviour
// - Lock input blocks writes to control, override enable and event mask.
// - Debug break is a fault source unless break_fault_disable is set.
// - Accepted break enters fault state and performs the fault action.
// - After break: cycle mode restarts at update, latched waits flag clear.
// - Control bit 5 selects pattern mode; low dead-time register holds pattern.
// - Control bit 4 feeds channel A waveform to every generator.
// - Control bits 3:0 enable each channel's dead-time generator.
// - Eight mask bits enable event channels, ORed into one fault.
// - Fault sets the detect flag and runs the selected action.
// - Fault control bit 2: zero latched, one cycle-by-cycle restart.
// - Latched: leave fault when condition gone and flag cleared, at update.
// - Cycle mode: leave fault at update once condition is gone.
// - Action 00 disables protection; 11 clears enabled channel directions.
// - Status bit 2 fault flag set by fault, cleared by writing one.
// - Status bits 1:0 show pending buffers; lock-update holds the copy.
// - Both-sides write loads high and low dead-time together.
// - Both-sides buffer write loads both buffers together.
// - Low and high dead-time registers hold 8-bit clock counts.
// - Valid buffers copy into active registers on update.
// - Override enable writes accepted only while the fault flag is zero.
// - Each override bit enables output override of its pin only.
// - Dead-time counter decrements, forces off, reloads on input edges.
// - Fault action within two clock cycles of the event.
// - Leaving fault restores direction bits of enabled channels.
package wdf_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_FCTRL = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_DT_BOTH = 4'h6;
    localparam logic [3:0] ADDR_DT_BOTH_BUF = 4'h7;
    localparam logic [3:0] ADDR_DT_LOW = 4'h8;
    localparam logic [3:0] ADDR_DT_HIGH = 4'h9;
    localparam logic [3:0] ADDR_DT_LOW_BUF = 4'ha;
    localparam logic [3:0] ADDR_DT_HIGH_BUF = 4'hb;
    localparam logic [3:0] ADDR_OVERRIDE = 4'hc;
    localparam int CTRL_PATTERN_BIT = 5;
    localparam int CTRL_COMMON_BIT = 4;
    localparam int FCTRL_BFD_BIT = 4;
    localparam int FCTRL_MODE_BIT = 2;
    localparam int STATUS_FLAG_BIT = 2;
    localparam int STATUS_HSV_BIT = 1;
    localparam int STATUS_LSV_BIT = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h3f;
    localparam logic [7:0] FCTRL_WMASK = 8'h17;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_CLEAR_DIR = 2'h3;
    localparam int NUM_CH = 4;
    localparam int FAULT_LATENCY_CYCLES = 2;
    typedef enum logic [1:0] {WDF_RUN, WDF_FAULT, WDF_WAIT_UPD} wdf_fstate_t;
endpackage

/* File: design/wdf_deadtime_gen.sv */
/*
 One dead-time generator: low side follows input, high side its inverse.
 Assumes the waveform input is synchronous to the clock.
*/
`timescale 1ns/100ps
module wdf_deadtime_gen
    import wdf_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Control
    input wire logic i_enable,
    input wire logic i_wave,
    input wire logic [WIDTH-1:0] i_low_time,
    input wire logic [WIDTH-1:0] i_high_time,
    // Outputs
    output logic o_low_side,
    output logic o_high_side
);
    initial begin
        if (WIDTH < 1) begin
            $error("WIDTH must be positive");
        end
    end
    logic [WIDTH-1:0] count_q, count_d;
    logic wave_q, wave_d;
    logic low_q, low_d, high_q, high_d;

    always_comb begin
        wave_d = i_wave;
        count_d = count_q;
        if (!i_enable) begin
            count_d = '0;
        end else if (i_wave && !wave_q) begin
            count_d = i_low_time;
        end else if (!i_wave && wave_q) begin
            count_d = i_high_time;
        end else if (count_q != '0) begin
            count_d = count_q - WIDTH'(1);
        end
        low_d = 1'b0;
        high_d = 1'b0;
        if (count_d == '0) begin
            low_d = i_wave;
            high_d = !i_wave;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= '0;
            wave_q <= 1'b0;
            low_q <= 1'b0;
            high_q <= 1'b0;
        end else begin
            count_q <= count_d;
            wave_q <= wave_d;
            low_q <= low_d;
            high_q <= high_d;
        end
    end
    assign o_low_side = low_q;
    assign o_high_side = high_q;
endmodule

/* File: design/wdf_fault_unit.sv */
/*
 Fault detection and restart state machine.
 Assumes events are one-cycle pulses synchronous to the clock.
*/
`timescale 1ns/100ps
module wdf_fault_unit
    import wdf_pkg::*;
#(
    parameter int NUM_EV = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Configuration
    input wire logic [NUM_EV-1:0] i_mask,
    input wire logic [NUM_EV-1:0] i_events,
    input wire logic i_break,
    input wire logic i_break_disable,
    input wire logic i_cycle_mode,
    input wire logic [1:0] i_action,
    input wire logic i_update,
    input wire logic i_flag,
    // Results
    output logic o_fault_event,
    output logic o_in_fault
);
    initial begin
        if (NUM_EV < 1) begin
            $error("NUM_EV must be positive");
        end
    end
    wdf_fstate_t state_q, state_d;
    logic cond;
    logic enabled;

    always_comb begin
        enabled = (i_action != ACT_NONE);
        cond = enabled && ((|(i_mask & i_events))
            || (i_break && !i_break_disable));
        state_d = state_q;
        case (state_q)
            WDF_RUN: begin
                if (cond) begin
                    state_d = WDF_FAULT;
                end
            end
            WDF_FAULT: begin
                if (cond) begin
                    state_d = WDF_FAULT;
                end else if (i_cycle_mode || !i_flag) begin
                    state_d = WDF_WAIT_UPD;
                end
            end
            WDF_WAIT_UPD: begin
                if (cond) begin
                    state_d = WDF_FAULT;
                end else if (!i_cycle_mode && i_flag) begin
                    state_d = WDF_FAULT;
                end else if (i_update) begin
                    state_d = WDF_RUN;
                end
            end
            default: state_d = WDF_RUN;
        endcase
        if (!enabled) begin
            state_d = WDF_RUN;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= WDF_RUN;
        end else begin
            state_q <= state_d;
        end
    end
    assign o_fault_event = cond;
    assign o_in_fault = (state_q != WDF_RUN);
endmodule

/* File: design/wdf_top.sv */
/*
 Waveform extension: registers, dead-time insertion, pattern, fault logic.
 Assumes waveform, event, break and update inputs are clock synchronous.
*/
`timescale 1ns/100ps
module wdf_top
    import wdf_pkg::*;
#(
    parameter int NUM_EV = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Timer and system
    input wire logic [NUM_CH-1:0] i_wave,
    input wire logic i_update,
    input wire logic i_timer_lock_update,
    input wire logic i_extension_lock,
    input wire logic i_debug_break,
    input wire logic [NUM_EV-1:0] i_events,
    // Port side
    output logic [7:0] o_pin_value,
    output logic [7:0] o_output_override_bits,
    output logic [7:0] o_dir_clear_mask,
    output logic o_in_fault,
    output logic o_fault_event
);
    initial begin
        if (NUM_EV != 8) begin
            $error("NUM_EV must be 8 to fit the mask register");
        end
    end
    logic [7:0] ctrl_q, ctrl_d, mask_q, mask_d, fctrl_q, fctrl_d;
    logic [7:0] lowdt_q, lowdt_d, highdt_q, highdt_d;
    logic [7:0] lsbuf_q, lsbuf_d, hsbuf_q, hsbuf_d;
    logic [7:0] oven_q, oven_d;
    logic lsv_q, lsv_d, hsv_q, hsv_d, flag_q, flag_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] pin_q, pin_d, dirclr_q, dirclr_d;
    logic infault_q, infault_d, fev_q, fev_d;
    logic fault_event, in_fault, commit;
    logic [NUM_CH-1:0] dt_in, ls_out, hs_out;
    logic [3:0] dt_en;

    function automatic logic wr_at(input logic [3:0] a);
        wr_at = i_wr && (i_addr == a);
    endfunction

    assign dt_en = ctrl_q[3:0];
    assign commit = i_update && !i_timer_lock_update;

    wdf_fault_unit #(
        .NUM_EV(NUM_EV)
    ) u_fault (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_mask(mask_q),
        .i_events(i_events),
        .i_break(i_debug_break),
        .i_break_disable(fctrl_q[FCTRL_BFD_BIT]),
        .i_cycle_mode(fctrl_q[FCTRL_MODE_BIT]),
        .i_action(fctrl_q[1:0]),
        .i_update(i_update),
        .i_flag(flag_q),
        .o_fault_event(fault_event),
        .o_in_fault(in_fault)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gen_dt
            assign dt_in[g] = ctrl_q[CTRL_COMMON_BIT] ? i_wave[0] : i_wave[g];
            wdf_deadtime_gen #(
                .WIDTH(8)
            ) u_dt (
                .i_clock(i_clock),
                .i_reset_n(i_reset_n),
                .i_enable(dt_en[g] && !ctrl_q[CTRL_PATTERN_BIT]),
                .i_wave(dt_in[g]),
                .i_low_time(lowdt_q),
                .i_high_time(highdt_q),
                .o_low_side(ls_out[g]),
                .o_high_side(hs_out[g])
            );
        end
    endgenerate

    // Register writes and status
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        fctrl_d = fctrl_q;
        oven_d = oven_q;
        lowdt_d = lowdt_q;
        highdt_d = highdt_q;
        lsbuf_d = lsbuf_q;
        hsbuf_d = hsbuf_q;
        lsv_d = lsv_q;
        hsv_d = hsv_q;
        flag_d = flag_q;
        if (!i_extension_lock) begin
            if (wr_at(ADDR_CTRL)) begin
                ctrl_d = i_wdata & CTRL_WMASK;
            end
            if (wr_at(ADDR_MASK)) begin
                mask_d = i_wdata;
            end
            if (wr_at(ADDR_OVERRIDE) && !flag_q) begin
                oven_d = i_wdata;
            end
        end
        if (wr_at(ADDR_FCTRL)) begin
            fctrl_d = i_wdata & FCTRL_WMASK;
        end
        if (commit && lsv_q) begin
            lowdt_d = lsbuf_q;
            lsv_d = 1'b0;
        end
        if (commit && hsv_q) begin
            highdt_d = hsbuf_q;
            hsv_d = 1'b0;
        end
        if (wr_at(ADDR_DT_BOTH)) begin
            lowdt_d = i_wdata;
            highdt_d = i_wdata;
        end
        if (wr_at(ADDR_DT_LOW)) begin
            lowdt_d = i_wdata;
        end
        if (wr_at(ADDR_DT_HIGH)) begin
            highdt_d = i_wdata;
        end
        if (wr_at(ADDR_DT_BOTH_BUF)) begin
            lsbuf_d = i_wdata;
            hsbuf_d = i_wdata;
            lsv_d = 1'b1;
            hsv_d = 1'b1;
        end
        if (wr_at(ADDR_DT_LOW_BUF)) begin
            lsbuf_d = i_wdata;
            lsv_d = 1'b1;
        end
        if (wr_at(ADDR_DT_HIGH_BUF)) begin
            hsbuf_d = i_wdata;
            hsv_d = 1'b1;
        end
        // Set wins over a same-cycle write-one clear
        if (wr_at(ADDR_STATUS) && i_wdata[STATUS_FLAG_BIT]) begin
            flag_d = 1'b0;
        end
        if (fault_event) begin
            flag_d = 1'b1;
        end
    end

    // Read data and pin outputs
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: rdata_d = ctrl_q;
                ADDR_MASK: rdata_d = mask_q;
                ADDR_FCTRL: rdata_d = fctrl_q;
                ADDR_STATUS: begin
                    rdata_d[STATUS_FLAG_BIT] = flag_q;
                    rdata_d[STATUS_HSV_BIT] = hsv_q;
                    rdata_d[STATUS_LSV_BIT] = lsv_q;
                end
                ADDR_DT_LOW: rdata_d = lowdt_q;
                ADDR_DT_HIGH: rdata_d = highdt_q;
                ADDR_DT_LOW_BUF: rdata_d = lsbuf_q;
                ADDR_DT_HIGH_BUF: rdata_d = hsbuf_q;
                ADDR_OVERRIDE: rdata_d = oven_q;
                default: rdata_d = 8'h00;
            endcase
        end
        pin_d = 8'h00;
        if (ctrl_q[CTRL_PATTERN_BIT]) begin
            // Pattern held in low-side register, channel A on override pins
            pin_d = (lowdt_q & ~oven_q) | ({8{i_wave[0]}} & oven_q);
        end else begin
            for (int k = 0; k < NUM_CH; k++) begin
                pin_d[2*k] = dt_en[k] ? ls_out[k] : i_wave[k];
                pin_d[2*k+1] = dt_en[k] ? hs_out[k] : 1'b0;
            end
        end
        dirclr_d = 8'h00;
        // Clearing ends one cycle after the state returns to run, together with o_in_fault
        if (in_fault && fctrl_q[1:0] == ACT_CLEAR_DIR) begin
            for (int k = 0; k < NUM_CH; k++) begin
                dirclr_d[2*k] = dt_en[k];
                dirclr_d[2*k+1] = dt_en[k];
            end
        end
        infault_d = in_fault;
        fev_d = fault_event;
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= REG_RESET;
            mask_q <= REG_RESET;
            fctrl_q <= REG_RESET;
            oven_q <= REG_RESET;
            lowdt_q <= REG_RESET;
            highdt_q <= REG_RESET;
            lsbuf_q <= REG_RESET;
            hsbuf_q <= REG_RESET;
            lsv_q <= 1'b0;
            hsv_q <= 1'b0;
            flag_q <= 1'b0;
            rdata_q <= 8'h00;
            pin_q <= 8'h00;
            dirclr_q <= 8'h00;
            infault_q <= 1'b0;
            fev_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            fctrl_q <= fctrl_d;
            oven_q <= oven_d;
            lowdt_q <= lowdt_d;
            highdt_q <= highdt_d;
            lsbuf_q <= lsbuf_d;
            hsbuf_q <= hsbuf_d;
            lsv_q <= lsv_d;
            hsv_q <= hsv_d;
            flag_q <= flag_d;
            rdata_q <= rdata_d;
            pin_q <= pin_d;
            dirclr_q <= dirclr_d;
            infault_q <= infault_d;
            fev_q <= fev_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_pin_value = pin_q;
    assign o_output_override_bits = oven_q;
    assign o_dir_clear_mask = dirclr_q;
    assign o_in_fault = infault_q;
    assign o_fault_event = fev_q;
endmodule

/* File: testbench/wdf_timer_model.sv */
/*
 Timer side model: single-slope counter giving four waveforms and UPDATE.
 Assumes the block samples both on the same rising clock edge.
*/
`timescale 1ns/100ps
module wdf_timer_model #(
    parameter int PERIOD = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Waveforms and update
    output logic [3:0] o_wave,
    output logic o_update
);
    logic [7:0] count_q;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= 8'h00;
        end else if (count_q == 8'(PERIOD - 1)) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_q + 8'h01;
        end
    end
    // Staggered compares so falling edges land on different cycles; all channels rise together at zero
    always_comb begin
        o_update = (count_q == 8'(PERIOD - 1));
        for (int k = 0; k < 4; k++) begin
            o_wave[k] = (count_q < 8'(4 + 2 * k));
        end
    end
endmodule

/* File: testbench/wdf_top_checker.sv */
/*
 Port-level assertions for the waveform extension.
 Assumes one clock and the active-low asynchronous reset of the top.
*/
`timescale 1ns/100ps
module wdf_top_checker
    import wdf_pkg::*;
#(
    parameter int NUM_EV = 8
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_update,
    input wire logic i_debug_break,
    input wire logic [NUM_EV-1:0] i_events,
    input wire logic [7:0] o_output_override_bits,
    input wire logic [7:0] o_dir_clear_mask,
    input wire logic o_in_fault,
    input wire logic o_fault_event
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_event_cause: assert property (o_fault_event |->
        ($past(i_events) != '0 || $past(i_debug_break)))
        else $error("fault event without a cause");
    chk_fault_entry: assert property ($rose(o_fault_event)
        |=> o_in_fault)
        else $error("fault state late");
    chk_entry_cause: assert property ($rose(o_in_fault)
        |-> $past(o_fault_event))
        else $error("fault state without fault event");
    chk_exit_update: assert property ($fell(o_in_fault) |->
        ($past(i_update) || $past(i_update, 2) || $past(i_update, 3)))
        else $error("fault exit without update");
    chk_dir_restore: assert property ($fell(o_in_fault) |=>
        o_dir_clear_mask == 8'h00)
        else $error("direction mask not restored");
    chk_dir_pairs: assert property ((o_dir_clear_mask & 8'h55) ==
        ((o_dir_clear_mask >> 1) & 8'h55))
        else $error("direction mask splits a channel pair");
    chk_dir_fault: assert property (o_dir_clear_mask != 8'h00 |->
        (o_in_fault || $past(o_in_fault)))
        else $error("direction mask outside fault");
    chk_override_hold: assert property (!$past(i_wr) && !$past(i_wr, 2)
        |-> $stable(o_output_override_bits))
        else $error("override bits changed without a write");

    cover property ($rose(o_in_fault));
    cover property ($fell(o_in_fault));
    cover property (o_dir_clear_mask != 8'h00);
endmodule

bind wdf_top wdf_top_checker #(.NUM_EV(NUM_EV)) checker_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_update(i_update),
    .i_debug_break(i_debug_break), .i_events(i_events),
    .o_output_override_bits(o_output_override_bits),
    .o_dir_clear_mask(o_dir_clear_mask), .o_in_fault(o_in_fault),
    .o_fault_event(o_fault_event)
);

/* File: testbench/wdf_top_tb.sv */
/*
 Self-checking bench for the waveform extension top.
 Assumes the timer model supplies waveforms and UPDATE every 16 cycles.
*/
`timescale 1ns/100ps
module wdf_top_tb;
    import wdf_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_timer_lock_update = 1'b0;
    logic i_extension_lock = 1'b0;
    logic i_debug_break = 1'b0;
    logic [7:0] i_events = 8'h00;
    logic [7:0] o_rdata, o_pin_value, o_output_override_bits;
    logic [7:0] o_dir_clear_mask;
    logic o_in_fault, o_fault_event, upd, rd_pend = 1'b0;
    logic [3:0] wave;
    logic [7:0] exp_q[$];
    logic [7:0] rnd = 8'h21;
    logic [7:0] old;
    int err_count = 0;
    int comparisons = 0;

    always #12.5 i_clock = ~i_clock;

    wdf_timer_model #(.PERIOD(16)) timer (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .o_wave(wave), .o_update(upd));
    wdf_top #(.NUM_EV(8)) uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_wave(wave), .i_update(upd),
        .i_timer_lock_update(i_timer_lock_update),
        .i_extension_lock(i_extension_lock), .i_debug_break(i_debug_break),
        .i_events(i_events), .o_pin_value(o_pin_value),
        .o_output_override_bits(o_output_override_bits),
        .o_dir_clear_mask(o_dir_clear_mask), .o_in_fault(o_in_fault),
        .o_fault_event(o_fault_event));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check_val(input string name, input logic [7:0] e,
                             input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    // Data goes out unchanged from here; callers keep reserved bits zero
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_clock);
        i_rd <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic pulse_event(input logic [7:0] ev);
        @(posedge i_clock);
        i_events <= ev;
        @(posedge i_clock);
        i_events <= 8'h00;
    endtask

    task automatic check_fault(input logic f, input logic [7:0] dir);
        check_val("in fault", {7'h00, f}, {7'h00, o_in_fault});
        check_val("direction clear", dir, o_dir_clear_mask);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (rd_pend) begin
            check_val("read data", exp_q.pop_front(), o_rdata);
        end
        rd_pend <= i_rd;
    end

    initial begin
        repeat (5000) @(posedge i_clock);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge i_clock);
        i_reset_n <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            reg_rd(4'(k), 8'h00);
        end
        reg_wr(ADDR_CTRL, 8'h3f);
        reg_rd(ADDR_CTRL, 8'h3f);
        reg_wr(ADDR_FCTRL, 8'h17);
        reg_rd(ADDR_FCTRL, 8'h17);
        i_extension_lock <= 1'b1;
        reg_wr(ADDR_CTRL, 8'h00);
        reg_wr(ADDR_MASK, 8'hff);
        reg_wr(ADDR_OVERRIDE, 8'hff);
        reg_rd(ADDR_CTRL, 8'h3f);
        reg_rd(ADDR_MASK, 8'h00);
        reg_rd(ADDR_OVERRIDE, 8'h00);
        i_extension_lock <= 1'b0;
        rnd = lfsr(rnd);
        reg_wr(ADDR_DT_BOTH, rnd);
        reg_rd(ADDR_DT_LOW, rnd);
        reg_rd(ADDR_DT_HIGH, rnd);
        old = rnd;
        rnd = lfsr(rnd);
        i_timer_lock_update <= 1'b1;
        reg_wr(ADDR_DT_BOTH_BUF, rnd);
        reg_rd(ADDR_STATUS, 8'h03);
        settle(40);
        reg_rd(ADDR_STATUS, 8'h03);
        reg_rd(ADDR_DT_HIGH, old);
        i_timer_lock_update <= 1'b0;
        settle(40);
        reg_rd(ADDR_STATUS, 8'h00);
        reg_rd(ADDR_DT_LOW, rnd);
        reg_rd(ADDR_DT_HIGH_BUF, rnd);
        rnd = lfsr(rnd);
        reg_wr(ADDR_OVERRIDE, rnd);
        settle(2);
        check_val("override", rnd, o_output_override_bits);
        // Latched restart with clear-direction on channels A and B
        reg_wr(ADDR_CTRL, 8'h03);
        reg_wr(ADDR_MASK, 8'h04);
        reg_wr(ADDR_FCTRL, 8'h03);
        pulse_event(8'h08);
        settle(4);
        check_fault(1'b0, 8'h00);
        pulse_event(8'h04);
        settle(2);
        check_fault(1'b1, 8'h0f);
        reg_rd(ADDR_STATUS, 8'h04);
        reg_wr(ADDR_OVERRIDE, ~rnd);
        reg_rd(ADDR_OVERRIDE, rnd);
        settle(40);
        check_fault(1'b1, 8'h0f);
        // Dead time far above the timer period keeps both sides off
        check_val("dead time", 8'h00, o_pin_value & 8'h0f);
        reg_wr(ADDR_STATUS, 8'h04);
        reg_rd(ADDR_STATUS, 8'h00);
        settle(40);
        check_fault(1'b0, 8'h00);
        // Cycle-by-cycle restart driven by a debug break
        reg_wr(ADDR_FCTRL, 8'h07);
        i_debug_break <= 1'b1;
        settle(40);
        check_fault(1'b1, 8'h0f);
        i_debug_break <= 1'b0;
        settle(40);
        check_fault(1'b0, 8'h00);
        reg_rd(ADDR_STATUS, 8'h04);
        reg_wr(ADDR_STATUS, 8'h04);
        reg_wr(ADDR_FCTRL, 8'h17);
        i_debug_break <= 1'b1;
        settle(10);
        check_fault(1'b0, 8'h00);
        i_debug_break <= 1'b0;
        reg_wr(ADDR_FCTRL, 8'h04);
        pulse_event(8'h04);
        settle(4);
        check_fault(1'b0, 8'h00);
        reg_rd(ADDR_STATUS, 8'h00);
        reg_wr(ADDR_OVERRIDE, 8'h00);
        reg_wr(ADDR_DT_LOW, 8'ha5);
        reg_wr(ADDR_CTRL, 8'h20);
        settle(4);
        check_val("pins", 8'ha5, o_pin_value);
        settle(4);
        end_of_test();
    end
endmodule
